// ---- hdl/rate_gen_pkg.sv ----
/*
 * Constants, mode encodings and decode helpers for the fractional rate generator.
 * Assumes a single oscillator-rate clock shared by every user of this package.
 */
package rate_gen_pkg;
    // Reset values of the three divisor registers
    localparam logic [7:0] DIV_LOW_RST = 8'h01;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [7:0] FRAC_MODE_RST = 8'h00;

    // Field layout of the fraction and mode register
    localparam int FRAC_LSB = 0;
    localparam int FRAC_W = 4;
    localparam int MODE_LSB = 4;
    localparam int MODE_W = 2;

    // Oversampling mode encodings
    localparam logic [1:0] MODE_16X = 2'h0;
    localparam logic [1:0] MODE_8X = 2'h1;
    localparam logic [1:0] MODE_4X = 2'h2;

    // Last sample index of one bit for each oversampling factor
    localparam logic [3:0] LAST_16X = 4'hF;
    localparam logic [3:0] LAST_8X = 4'h7;
    localparam logic [3:0] LAST_4X = 4'h3;

    // Prescaler: terminal count for divide by 4
    localparam logic [1:0] PRESCALE4_LAST = 2'h3;

    // Fraction denominator expressed as the accumulator carry point
    localparam logic [4:0] FRAC_ONE = 5'h10;

    function automatic logic [3:0] last_sample(input logic [1:0] mode);
        case (mode)
            MODE_8X: last_sample = LAST_8X;
            MODE_4X: last_sample = LAST_4X;
            default: last_sample = LAST_16X;
        endcase
    endfunction : last_sample
endpackage : rate_gen_pkg

// ---- hdl/rate_prescaler.sv ----
/*
 * Prescaler: one-cycle enable at the oscillator rate, or at a quarter of it.
 * Assumes the select level comes from logic on the same clock.
 */
`timescale 1ns/10ps
module rate_prescaler (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic div4_sel,
    output logic pre_en
);
    typedef struct packed {
        logic [1:0] cnt;
        logic en;
    } pre_state_t;

    pre_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.cnt = s_q.cnt + 2'h1;
        s_d.en = div4_sel ? (s_q.cnt == rate_gen_pkg::PRESCALE4_LAST) : 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pre_en = s_q.en;
endmodule : rate_prescaler

// ---- hdl/fractional_rate_gen.sv ----
/*
 * Fractional rate generator for one serial channel: divisor registers, prescaler,
 * integer plus sixteenths divider, and the per-bit oversampling counter.
 * Assumes register writes arrive as one-cycle strobes on the oscillator clock and
 * that the prescale select level comes from the modem control logic.
 */
`timescale 1ns/10ps
module fractional_rate_gen (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic prescale_sel,
    input wire logic div_low_wr,
    input wire logic div_high_wr,
    input wire logic frac_mode_wr,
    input wire logic [7:0] wr_data,
    output logic [7:0] divisor_low_byte,
    output logic [7:0] divisor_high_byte,
    output logic [7:0] divisor_fraction_and_mode,
    output logic sample_tick,
    output logic bit_tick
);
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] frac_mode;
        logic [16:0] cnt;
        logic [3:0] acc;
        logic [3:0] smp;
        logic sample;
        logic bit_end;
    } gen_state_t;

    gen_state_t s_q, s_d;
    logic pre_en;
    logic [15:0] int_div;
    logic [3:0] frac;
    logic [1:0] mode;
    logic [4:0] acc_sum;
    logic [16:0] target;

    rate_prescaler u_prescaler (
        .core_clk(core_clk),
        .resetn(resetn),
        .div4_sel(prescale_sel),
        .pre_en(pre_en)
    );

    always_comb begin
        int_div = {s_q.high, s_q.low};
        frac = s_q.frac_mode[rate_gen_pkg::FRAC_LSB +: rate_gen_pkg::FRAC_W];
        mode = s_q.frac_mode[rate_gen_pkg::MODE_LSB +: rate_gen_pkg::MODE_W];
        acc_sum = {1'b0, s_q.acc} + {1'b0, frac};
        // Carry lengthens this period
        // An integer of zero runs as one so the divider never stalls
        target = {1'b0, (int_div == 16'h0000) ? 16'h0001 : int_div}
            + {16'h0000, (acc_sum >= rate_gen_pkg::FRAC_ONE)};
    end

    always_comb begin
        s_d = s_q;
        s_d.sample = 1'b0;
        s_d.bit_end = 1'b0;
        if (div_low_wr) begin
            s_d.low = wr_data;
        end
        if (div_high_wr) begin
            s_d.high = wr_data;
        end
        if (frac_mode_wr) begin
            s_d.frac_mode = wr_data;
        end
        if (pre_en) begin
            if (s_q.cnt >= target) begin
                s_d.cnt = 17'h00001;
                s_d.acc = acc_sum[3:0];
                s_d.sample = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 17'h00001;
            end
        end
        if (s_q.sample) begin
            if (s_q.smp >= rate_gen_pkg::last_sample(mode)) begin
                s_d.smp = 4'h0;
                s_d.bit_end = 1'b1;
            end else begin
                s_d.smp = s_q.smp + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '{low: rate_gen_pkg::DIV_LOW_RST, high: rate_gen_pkg::DIV_HIGH_RST,
                     frac_mode: rate_gen_pkg::FRAC_MODE_RST, cnt: 17'h00001,
                     acc: 4'h0, smp: 4'h0, sample: 1'b0, bit_end: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign sample_tick = s_q.sample;
    assign bit_tick = s_q.bit_end;
    assign divisor_low_byte = s_q.low;
    assign divisor_high_byte = s_q.high;
    assign divisor_fraction_and_mode = s_q.frac_mode;

    // Checking helpers: cycles between ticks, and whether settings held steady
    logic [17:0] gap_q;
    logic seen_q, settled_q, sel_prev_q;
    logic chg;
    assign chg = div_low_wr || div_high_wr || frac_mode_wr || (prescale_sel != sel_prev_q);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            gap_q <= 18'h00001;
            seen_q <= 1'b0;
            settled_q <= 1'b0;
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= prescale_sel;
            gap_q <= sample_tick ? 18'h00001 : gap_q + 18'h00001;
            if (chg) begin
                seen_q <= 1'b0;
                settled_q <= 1'b0;
            end else if (sample_tick) begin
                seen_q <= 1'b1;
                settled_q <= seen_q;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_RESET_DEFAULTS: assert property (
        @(posedge core_clk) disable iff (1'b0)
        !resetn |=> (divisor_low_byte == 8'h01 && divisor_high_byte == 8'h00
            && divisor_fraction_and_mode == 8'h00))
        else $error("divisor registers not at reset defaults");

    AST_PRESCALE_BY1: assert property (
        $past(resetn) && !$past(prescale_sel) |-> pre_en)
        else $error("prescaler by one missed an enable");

    AST_PRESCALE_BY4: assert property (
        pre_en && $past(prescale_sel) && prescale_sel |=> !pre_en)
        else $error("prescaler by four enabled twice in a row");

    AST_WRITE_LOW: assert property (
        div_low_wr && !div_high_wr |=> divisor_low_byte == $past(wr_data)
            && int_div[7:0] == $past(wr_data))
        else $error("low divisor byte write lost");

    AST_DIV_ONE: assert property (
        sample_tick && int_div == 16'h0001 && frac == 4'h0 && settled_q
            && !prescale_sel && !chg |=> sample_tick)
        else $error("divisor one did not tick every cycle");

    AST_INT_PERIOD: assert property (
        sample_tick && settled_q && !prescale_sel && frac == 4'h0 && int_div != 16'h0000
        |-> gap_q == {2'b00, int_div})
        else $error("integer divisor period wrong");

    AST_FRAC_STRETCH: assert property (
        sample_tick && settled_q && !prescale_sel && frac != 4'h0 && int_div != 16'h0000
        |-> (gap_q == {2'b00, int_div} || gap_q == {2'b00, int_div} + 18'h00001))
        else $error("fractional period outside divisor and divisor plus one");

    // Limit taken from the mode of the previous cycle: a mode write may land with the bit end
    AST_BIT_SAMPLES: assert property (
        bit_tick |-> $past(sample_tick)
            && $past(s_q.smp) >= rate_gen_pkg::last_sample($past(mode))
            ##1 !bit_tick)
        else $error("bit tick without a full sample count");

    AST_RESERVED_MODE: assert property (
        mode == 2'h3 && sample_tick && s_q.smp < 4'hF |=> !bit_tick)
        else $error("reserved mode ended a bit before sixteen samples");

    AST_TICKS_QUIET: assert property (
        @(posedge core_clk) disable iff (1'b0)
        !resetn |=> !sample_tick && !bit_tick)
        else $error("tick output active after a reset cycle");

    AST_WRITE_HIGH: assert property (
        div_high_wr |=> divisor_high_byte == $past(wr_data)
            && int_div[15:8] == $past(wr_data))
        else $error("high divisor byte write lost");

    AST_FRAC_FIELD: assert property (
        frac_mode_wr |=> divisor_fraction_and_mode == $past(wr_data)
            && frac == $past(wr_data[3:0]))
        else $error("fraction field write lost");

    AST_MODE_FIELD: assert property (
        frac_mode_wr |=> mode == $past(wr_data[5:4]))
        else $error("mode field write lost");
endmodule : fractional_rate_gen

// ---- sim/uart_shift_model.sv ----
/* Stand-in for the tx/rx shift logic of one channel: counts samples per bit.
   Assumes both ticks are one-cycle pulses on core_clk. */
`timescale 1ns/10ps
module uart_shift_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sample_tick,
    input wire logic bit_tick,
    output logic [4:0] samples_per_bit
);
    logic [4:0] cnt_q;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cnt_q <= 5'h00;
            samples_per_bit <= 5'h00;
        end else if (bit_tick) begin
            samples_per_bit <= cnt_q;
            cnt_q <= {4'h0, sample_tick};
        end else if (sample_tick) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule : uart_shift_model

// ---- sim/test_fractional_rate_gen.sv ----
/* Self-checking bench for the fractional rate generator.
   Assumes the design's registers are written by one-cycle strobes. */
`timescale 1ns/10ps
module test_fractional_rate_gen;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic prescale_sel = 1'b0;
    logic div_low_wr = 1'b0;
    logic div_high_wr = 1'b0;
    logic frac_mode_wr = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] lo_b, hi_b, fm_b;
    logic sample_tick, bit_tick;
    logic [4:0] spb;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    int c;

    fractional_rate_gen dut (.core_clk(core_clk), .resetn(resetn), .prescale_sel(prescale_sel),
        .div_low_wr(div_low_wr), .div_high_wr(div_high_wr), .frac_mode_wr(frac_mode_wr),
        .wr_data(wr_data), .divisor_low_byte(lo_b), .divisor_high_byte(hi_b),
        .divisor_fraction_and_mode(fm_b), .sample_tick(sample_tick), .bit_tick(bit_tick));
    uart_shift_model shift (.core_clk(core_clk), .resetn(resetn), .sample_tick(sample_tick),
        .bit_tick(bit_tick), .samples_per_bit(spb));

    always #12.5 core_clk = ~core_clk;

    task automatic complete_run;
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // Strobe bits: 1 low byte, 2 high byte, 4 fraction and mode
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge core_clk);
        wr_data <= d;
        {frac_mode_wr, div_high_wr, div_low_wr} <= s;
        @(posedge core_clk);
        {frac_mode_wr, div_high_wr, div_low_wr} <= 3'h0;
    endtask : wr

    // Cycles spanned by k ticks (bit ticks if w), starting at a tick
    task automatic span(input logic w, input int k, output int n);
        int t;
        t = 0;
        n = 0;
        do @(negedge core_clk); while ((w ? bit_tick : sample_tick) !== 1'b1);
        while (t < k) begin
            @(negedge core_clk);
            n++;
            if ((w ? bit_tick : sample_tick) === 1'b1) t++;
        end
    endtask : span

    // First span discarded: it may straddle the register change
    task automatic run(input logic [7:0] fr, input logic [7:0] lo, input logic w, input int k,
            input int e);
        wr(3'h1, lo);
        wr(3'h4, fr);
        span(w, k, c);
        span(w, k, c);
        chk("period", e, c);
    endtask : run

    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        @(negedge core_clk);
        chk("low", 8'h01, lo_b);
        chk("high", 8'h00, hi_b);
        chk("frac", 8'h00, fm_b);
        span(1'b0, 16, c);
        chk("period", 16, c);
        wr(3'h2, 8'hA5);
        wr(3'h1, 8'h3C);
        wr(3'h4, 8'hC0);
        @(negedge core_clk);
        chk("word", 24'hA53CC0, {hi_b, lo_b, fm_b});
        wr(3'h2, 8'h01);
        run(8'h00, 8'h00, 1'b0, 2, 512);
        wr(3'h2, 8'h00);
        run(8'h00, 8'h02, 1'b0, 16, 32);
        @(posedge core_clk);
        prescale_sel <= 1'b1;
        run(8'h00, 8'h02, 1'b0, 16, 128);
        @(posedge core_clk);
        prescale_sel <= 1'b0;
        run(8'h01, 8'h02, 1'b0, 16, 33);
        run(8'h08, 8'h02, 1'b0, 16, 40);
        run(8'h0F, 8'h02, 1'b0, 16, 47);
        for (int m = 0; m < 4; m++) begin
            run({2'h0, 2'(m), 4'h0}, 8'h03, 1'b1, 1, (m == 1) ? 24 : (m == 2) ? 12 : 48);
            chk("samples", (m == 1) ? 8 : (m == 2) ? 4 : 16, {27'h0, spb});
        end
        run(8'h15, 8'h03, 1'b1, 2, 53);
        run(8'h23, 8'h03, 1'b1, 4, 51);
        complete_run();
    end
endmodule : test_fractional_rate_gen
